// ---- hdl/ocp_params.svh ----
// Constants for the over-current fault response block
`ifndef OCP_PARAMS_SVH
`define OCP_PARAMS_SVH
`define OCP_CMD_LIMIT 8'h46
`define OCP_CMD_RESPONSE 8'h47
`define OCP_CMD_UNIT 8'hD2
`define OCP_RESP_MSB 7
`define OCP_RESP_LSB 6
`define OCP_RETRY_MSB 5
`define OCP_RETRY_LSB 3
`define OCP_TIME_MSB 2
`define OCP_TIME_LSB 0
`define OCP_RESPONSE_RESET 8'h00
`define OCP_LIMIT_RESET 16'h0000
`define OCP_UNIT_RESET 16'h0001
`define OCP_RETRY_NONE 3'h0
`define OCP_RETRY_FOREVER 3'h7
`define OCP_READ_RESET 16'h0000
`endif

// ---- hdl/ocp_pkg.sv ----
// Types for the over-current fault response block
package ocp_pkg;
  typedef enum logic [1:0] {
    resp_ignore = 2'b00,
    resp_cond_cc = 2'b01,
    resp_delay_cc = 2'b10,
    resp_disable = 2'b11
  } response_type;
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_limit = 3'b001,
    st_wait = 3'b010,
    st_latched = 3'b011
  } state_type;
endpackage

// ---- hdl/overcurrent_fault_response.sv ----
// Over-current fault policy: response setting, delay timing and restart control
//
// Summary of operation
// - Every over-current fault sets the fault flag and pulses host notification.
// - Code 00: keep running with constant-current limiting, forever.
// - Code 01: limit while voltage above threshold; below it shut down and retry.
// - Code 10: limit for time field delay; still limiting then shut down and retry.
// - Code 11: shut down at once, then follow the retry count.
// - Retry 000 means no restart; 111 means restart without end.
// - Retry 001..110 give that many restarts; then off until off command, fault clear or another fault.
// - Restart interval is time field count times the delay unit.
// - Response setting is a read/write byte at command 0x47.
// - Time field count doubles per step, 1 to 128 units; unit at 0xD2.
// - Endless retry stops only on off command, fault clear or another fault.
// - Over-current limit is a read/write word at command 0x46.
`timescale 1ns/1ns
`include "ocp_params.svh"
module overcurrent_fault_response #(
  parameter int UNIT_W = 16,
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Command register access
  input wire logic [7:0] cmd_code,
  input wire logic wr_byte,
  input wire logic wr_word,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  // Converter status
  input wire logic overcurrent,
  input wire logic below_lv_threshold,
  input wire logic output_commanded_on,
  input wire logic other_fault,
  input wire logic fault_clear,
  // Converter control
  output logic output_enable,
  output logic current_limit_active,
  output logic fault_flag,
  output logic host_alert,
  output logic [15:0] overcurrent_limit_level,
  output logic [15:0] delay_unit_cycles
);
  logic [7:0] overcurrent_response_setting_q;
  logic [15:0] limit_q;
  logic [15:0] rd_q;
  logic [UNIT_W-1:0] unit_q;
  ocp_pkg::state_type state_q, state_d;
  logic [CNT_W-1:0] timer_q, timer_d;
  logic [2:0] tries_q, tries_d;
  logic flag_q, alert_q, oc_q;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Units per time code: 1 << code, so 0 gives 1 and 7 gives 128
  function automatic logic [CNT_W-1:0] span(input logic [2:0] code,
                                            input logic [UNIT_W-1:0] unit);
    logic [CNT_W-1:0] u;
    u = CNT_W'(unit);
    span = u << code;
  endfunction

  wire ocp_pkg::response_type resp =
    ocp_pkg::response_type'(overcurrent_response_setting_q[`OCP_RESP_MSB:`OCP_RESP_LSB]);
  wire [2:0] retry_code = overcurrent_response_setting_q[`OCP_RETRY_MSB:`OCP_RETRY_LSB];
  wire [2:0] time_code = overcurrent_response_setting_q[`OCP_TIME_MSB:`OCP_TIME_LSB];
  wire [CNT_W-1:0] interval = span(time_code, unit_q);
  wire fault_rise = overcurrent && !oc_q;
  wire abort = fault_clear || !output_commanded_on || other_fault;
  wire retry_left = (retry_code == `OCP_RETRY_FOREVER) || (tries_q < retry_code);
  wire timer_done = (timer_q <= CNT_W'(1));
  wire sel_response = (cmd_code == `OCP_CMD_RESPONSE);
  wire sel_limit = (cmd_code == `OCP_CMD_LIMIT);
  wire sel_unit = (cmd_code == `OCP_CMD_UNIT);

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      overcurrent_response_setting_q <= `OCP_RESPONSE_RESET;
      limit_q <= `OCP_LIMIT_RESET;
      unit_q <= UNIT_W'(`OCP_UNIT_RESET);
    end else begin
      if (wr_byte && sel_response)
        overcurrent_response_setting_q <= wr_data[7:0];
      if (wr_word && sel_limit)
        limit_q <= wr_data;
      if (wr_word && sel_unit)
        unit_q <= wr_data[UNIT_W-1:0];
    end
  end

  // Unlisted codes read as zero; the read word is registered, so it
  // follows cmd_code one edge later and never glitches while the code settles
  wire [15:0] rd_d = sel_response ? {8'h00, overcurrent_response_setting_q} :
                     sel_limit ? limit_q :
                     sel_unit ? 16'(unit_q) :
                     16'h0000;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      rd_q <= `OCP_READ_RESET;
    else
      rd_q <= rd_d;
  end

  // ----------------------------------------------------------------
  // Response state machine
  // ----------------------------------------------------------------
  // After a shutdown, st_wait times the interval before each restart.
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    tries_d = tries_q;
    if (timer_q != '0)
      timer_d = timer_q - CNT_W'(1);
    case (state_q)
      ocp_pkg::st_run: begin
        if (overcurrent) begin
          case (resp)
            ocp_pkg::resp_ignore: state_d = ocp_pkg::st_limit;
            ocp_pkg::resp_cond_cc: state_d = ocp_pkg::st_limit;
            ocp_pkg::resp_delay_cc: begin
              state_d = ocp_pkg::st_limit;
              timer_d = interval;
            end
            default: begin
              state_d = retry_left ? ocp_pkg::st_wait : ocp_pkg::st_latched;
              timer_d = interval;
            end
          endcase
        end
      end
      ocp_pkg::st_limit: begin
        if (!overcurrent)
          state_d = ocp_pkg::st_run;
        else if ((resp == ocp_pkg::resp_cond_cc && below_lv_threshold) ||
                 (resp == ocp_pkg::resp_delay_cc && timer_done) ||
                 resp == ocp_pkg::resp_disable) begin
          state_d = retry_left ? ocp_pkg::st_wait : ocp_pkg::st_latched;
          timer_d = interval;
        end
      end
      ocp_pkg::st_wait: begin
        if (timer_done) begin
          state_d = ocp_pkg::st_run;
          if (retry_code != `OCP_RETRY_FOREVER)
            tries_d = tries_q + 3'h1;
        end
      end
      ocp_pkg::st_latched: state_d = ocp_pkg::st_latched;
      default: state_d = ocp_pkg::st_run;
    endcase
    if (abort) begin
      state_d = ocp_pkg::st_run;
      timer_d = '0;
      tries_d = 3'h0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ocp_pkg::st_run;
      timer_q <= '0;
      tries_q <= 3'h0;
      oc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      tries_q <= tries_d;
      oc_q <= overcurrent;
    end
  end

  // ----------------------------------------------------------------
  // Fault flag and host notification
  // ----------------------------------------------------------------
  // Fault set wins over a same-cycle clear so no event is lost.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      flag_q <= fault_rise || (flag_q && !fault_clear);
      alert_q <= fault_rise;
    end
  end

  assign rd_data = rd_q;
  assign fault_flag = flag_q;
  assign host_alert = alert_q;
  assign output_enable = (state_q == ocp_pkg::st_run) || (state_q == ocp_pkg::st_limit);
  assign current_limit_active = (state_q == ocp_pkg::st_limit);
  assign overcurrent_limit_level = limit_q;
  assign delay_unit_cycles = 16'(unit_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_flag_set;
    @(posedge mclk) disable iff (!reset_n) fault_rise |=> fault_flag && host_alert;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault not flagged");

  property p_ignore_runs;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ocp_pkg::st_limit && resp == ocp_pkg::resp_ignore && !abort) |=> output_enable;
  endproperty
  a_ignore_runs: assert property (p_ignore_runs) else $error("code 00 shut down");

  property p_lv_trip;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ocp_pkg::st_limit && resp == ocp_pkg::resp_cond_cc && overcurrent &&
       below_lv_threshold && !abort) |=> !output_enable;
  endproperty
  a_lv_trip: assert property (p_lv_trip) else $error("low voltage did not trip");

  property p_delay_trip;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ocp_pkg::st_limit && resp == ocp_pkg::resp_delay_cc && overcurrent &&
       timer_done && !abort) |=> !output_enable;
  endproperty
  a_delay_trip: assert property (p_delay_trip) else $error("delay expiry missed");

  property p_disable_now;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ocp_pkg::st_run && overcurrent && resp == ocp_pkg::resp_disable && !abort)
      |=> !output_enable;
  endproperty
  a_disable_now: assert property (p_disable_now) else $error("code 11 kept running");

  property p_latched_holds;
    @(posedge mclk) disable iff (!reset_n)
      (state_q == ocp_pkg::st_latched && !abort) |=> state_q == ocp_pkg::st_latched;
  endproperty
  a_latched_holds: assert property (p_latched_holds) else $error("latched off left");

  property p_tries_bound;
    @(posedge mclk) disable iff (!reset_n)
      (retry_code != `OCP_RETRY_FOREVER && state_q != ocp_pkg::st_wait &&
       state_d == ocp_pkg::st_wait) |-> tries_q < retry_code;
  endproperty
  a_tries_bound: assert property (p_tries_bound) else $error("too many restarts");

  property p_interval;
    @(posedge mclk) disable iff (!reset_n)
      (state_q != ocp_pkg::st_wait ##1 state_q == ocp_pkg::st_wait) |-> timer_q == interval;
  endproperty
  a_interval: assert property (p_interval) else $error("restart interval wrong");

  property p_abort_resets;
    @(posedge mclk) disable iff (!reset_n) abort |=> tries_q == 3'h0 && timer_q == '0;
  endproperty
  a_abort_resets: assert property (p_abort_resets) else $error("retry state kept");
endmodule // overcurrent_fault_response

// ---- sim/pmbus_host_model.sv ----
// Host side model issuing command register writes and reads
`timescale 1ns/1ns
module pmbus_host_model (
  // Clock
  input wire logic mclk,
  // Command access
  output logic [7:0] cmd_code,
  output logic wr_byte,
  output logic wr_word,
  output logic [15:0] wr_data,
  input wire logic [15:0] rd_data
);
  initial begin
    cmd_code = 8'h00;
    wr_byte = 1'b0;
    wr_word = 1'b0;
    wr_data = 16'h0000;
  end
  // One-edge strobe; released data is inverted so a stale value never looks valid
  task automatic write(input logic [7:0] code, input logic [15:0] data, input logic word);
    @(posedge mclk);
    cmd_code <= code;
    wr_data <= data;
    wr_byte <= !word;
    wr_word <= word;
    @(posedge mclk);
    wr_byte <= 1'b0;
    wr_word <= 1'b0;
    wr_data <= ~data;
  endtask
  task automatic read(input logic [7:0] code, output logic [15:0] data);
    @(posedge mclk);
    cmd_code <= code;
    @(posedge mclk);
    #1 data = rd_data;
  endtask
endmodule // pmbus_host_model

// ---- sim/tb_overcurrent_fault_response.sv ----
// Self-checking bench for the over-current fault response block
`timescale 1ns/1ns
module tb_overcurrent_fault_response;
  logic mclk, reset_n, overcurrent, below_lv_threshold, output_commanded_on;
  logic other_fault, fault_clear, wr_byte, wr_word;
  logic output_enable, current_limit_active, fault_flag, host_alert;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data, v;
  logic [15:0] limit_level, unit_cycles;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  pmbus_host_model host (.mclk(mclk), .cmd_code(cmd_code), .wr_byte(wr_byte),
    .wr_word(wr_word), .wr_data(wr_data), .rd_data(rd_data));
  overcurrent_fault_response dut (.mclk(mclk), .reset_n(reset_n), .cmd_code(cmd_code),
    .wr_byte(wr_byte), .wr_word(wr_word), .wr_data(wr_data), .rd_data(rd_data),
    .overcurrent(overcurrent), .below_lv_threshold(below_lv_threshold),
    .output_commanded_on(output_commanded_on), .other_fault(other_fault),
    .fault_clear(fault_clear), .output_enable(output_enable),
    .current_limit_active(current_limit_active), .fault_flag(fault_flag),
    .host_alert(host_alert), .overcurrent_limit_level(limit_level),
    .delay_unit_cycles(unit_cycles));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results();
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host.read(c, v);
    check(v, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Second edge samples the rise; keep holds the over-current level afterwards
  task automatic trip(input logic keep);
    @(posedge mclk);
    overcurrent <= 1'b1;
    @(posedge mclk);
    overcurrent <= keep;
    #1;
  endtask
  task automatic clear();
    @(posedge mclk);
    fault_clear <= 1'b1;
    @(posedge mclk);
    fault_clear <= 1'b0;
    overcurrent <= 1'b0;
    below_lv_threshold <= 1'b0;
    cyc(1);
  endtask
  // Counts the cycles until a restart brings the output back on
  task automatic wait_on(input int lo);
    int n;
    n = 0;
    while (output_enable !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    check(16'(n), 16'(lo));
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    {overcurrent, below_lv_threshold, other_fault, fault_clear} = 4'h0;
    output_commanded_on = 1'b1;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rd(8'h47, 16'h0000);
    rd(8'h46, 16'h0000);
    rd(8'hD2, 16'h0001);
    rd(8'h55, 16'h0000);
    host.write(8'h46, 16'h1234, 1'b1);
    rd(8'h46, 16'h1234);
    check(limit_level, 16'h1234);
    host.write(8'h47, 16'h00C0, 1'b0);
    host.write(8'h47, 16'h00FF, 1'b1);
    rd(8'h47, 16'h00C0);
    host.write(8'hD2, 16'h0002, 1'b1);
    rd(8'hD2, 16'h0002);
    check(unit_cycles, 16'h0002);
    trip(1'b0);
    check(16'(output_enable), 16'h0000);
    check(16'({fault_flag, host_alert}), 16'h0003);
    cyc(1);
    check(16'(host_alert), 16'h0000);
    cyc(40);
    check(16'(output_enable), 16'h0000);
    clear();
    check(16'({output_enable, fault_flag}), 16'h0002);
    host.write(8'h47, 16'h0000, 1'b0);
    trip(1'b1);
    cyc(300);
    check(16'({output_enable, current_limit_active}), 16'h0003);
    clear();
    host.write(8'h47, 16'h0040, 1'b0);
    trip(1'b1);
    check(16'({output_enable, current_limit_active}), 16'h0003);
    @(posedge mclk);
    below_lv_threshold <= 1'b1;
    cyc(3);
    check(16'(output_enable), 16'h0000);
    clear();
    // Two units of two cycles: limiting holds four cycles, then trips
    host.write(8'h47, 16'h0081, 1'b0);
    trip(1'b1);
    cyc(3);
    check(16'({output_enable, current_limit_active}), 16'h0003);
    cyc(2);
    check(16'(output_enable), 16'h0000);
    clear();
    host.write(8'h47, 16'h00CB, 1'b0);
    trip(1'b0);
    wait_on(16);
    trip(1'b0);
    cyc(60);
    check(16'(output_enable), 16'h0000);
    clear();
    host.write(8'h47, 16'h00F8, 1'b0);
    repeat (3) begin
      trip(1'b0);
      check(16'(output_enable), 16'h0000);
      wait_on(2);
    end
    // A long interval, so an abort shows before the restart could
    host.write(8'h47, 16'h00FB, 1'b0);
    trip(1'b0);
    @(posedge mclk);
    other_fault <= 1'b1;
    @(posedge mclk);
    other_fault <= 1'b0;
    #1;
    check(16'(output_enable), 16'h0001);
    trip(1'b0);
    @(posedge mclk);
    output_commanded_on <= 1'b0;
    @(posedge mclk);
    output_commanded_on <= 1'b1;
    #1;
    check(16'(output_enable), 16'h0001);
    results();
  end
endmodule // tb_overcurrent_fault_response
